// ### verilog/srfu_top.v
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ns
module srfu_top
(
    input wire aclk,
    input wire aresetn,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [7:0] status_register,
    output reg [7:0] result_reg,
    output reg irq_global_enable
);
`include "srfu_defs.vh"

reg aw_held;
reg w_held;
reg [3:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
reg [7:0] operand;
reg [3:0] last_op;
reg [2:0] last_idx;
reg [2:0] op_count;

wire [7:0] shift_result;
wire shift_carry;
wire picked_bit;
wire [7:0] status_register_replaced;
wire [7:0] rd_replaced;
reg [7:0] next_status;
reg [7:0] next_result;
reg [31:0] next_rdata;
reg [1:0] next_rresp;

// ctrl word: [3:0] op, [6:4] bit index, [15:8] operand
wire do_write = aw_held && w_held && !s_axi_bvalid;
wire ctrl_hit = do_write && aw_addr == `SRFU_ADDR_CTRL;
wire status_register_hit = do_write && aw_addr == `SRFU_ADDR_STATUS_REGISTER && w_strb[0];
wire [3:0] op = w_data[3:0];
wire [2:0] idx = w_data[6:4];
wire [7:0] wr_operand = w_strb[1] ? w_data[15:8] : operand;
wire lower = (op == `SRFU_OP_LOWER);

function [1:0] strobe_ok;
    input [3:0] addr;
    begin
        strobe_ok = (addr == `SRFU_ADDR_CTRL || addr == `SRFU_ADDR_STATUS_REGISTER)
            ? `SRFU_RESP_OKAY : `SRFU_RESP_DECERR;
    end
endfunction

// registers are whole words: byte lanes of the address are ignored
function [3:0] word_addr;
    input [3:0] addr;
    begin
        word_addr = {addr[3:2], 2'b00};
    end
endfunction

// flags after a shift: carry out, zero, sign, overflow as n xor c
function [7:0] flag_update;
    input [7:0] old_flags;
    input [7:0] res;
    input carry;
    begin
        flag_update = old_flags;
        flag_update[`SRFU_FLAG_C] = carry;
        flag_update[`SRFU_FLAG_Z] = (res == 8'h00);
        flag_update[`SRFU_FLAG_N] = res[7];
        flag_update[`SRFU_FLAG_V] = res[7] ^ carry;
    end
endfunction

srfu_shift u_shift
(
    .op(op),
    .operand(wr_operand),
    .carry_in(status_register[`SRFU_FLAG_C]),
    .result(shift_result),
    .carry_out(shift_carry)
);

srfu_bit_sel u_status_register_sel
(
    .value(status_register),
    .index(idx),
    .new_bit(~lower),
    .picked(),
    .replaced(status_register_replaced)
);

srfu_bit_sel u_rd_sel
(
    .value(wr_operand),
    .index(idx),
    .new_bit(status_register[`SRFU_FLAG_T]),
    .picked(picked_bit),
    .replaced(rd_replaced)
);

// operation datapath
always @*
begin
    next_status = status_register;
    next_result = result_reg;
    case (op)
        `SRFU_OP_NOP:
        begin
            next_status = status_register;
            next_result = result_reg;
        end
        `SRFU_OP_SHL, `SRFU_OP_SHR, `SRFU_OP_ROL, `SRFU_OP_ROR,
        `SRFU_OP_ASR:
        begin
            next_result = shift_result;
            next_status = flag_update(status_register, shift_result,
                shift_carry);
        end
        `SRFU_OP_SWAP:
        begin
            next_result = shift_result;
        end
        `SRFU_OP_RAISE, `SRFU_OP_LOWER:
        begin
            next_status = status_register_replaced;
        end
        `SRFU_OP_TSTORE:
        begin
            next_status[`SRFU_FLAG_T] = picked_bit;
        end
        `SRFU_OP_TLOAD:
        begin
            next_result = rd_replaced;
        end
        default:
        begin
            next_status = status_register;
            next_result = result_reg;
        end
    endcase
end

// write address: held until the data half has also arrived
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        aw_held <= 1'b0;
        aw_addr <= 4'h0;
        s_axi_awready <= 1'b0;
    end
    else
    begin
        s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held <= 1'b1;
            aw_addr <= word_addr(s_axi_awaddr);
        end
        else if (do_write)
        begin
            aw_held <= 1'b0;
        end
    end
end

// write data: taken before or after the address
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        w_held <= 1'b0;
        w_data <= 32'h00000000;
        w_strb <= 4'h0;
        s_axi_wready <= 1'b0;
    end
    else
    begin
        s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        else if (do_write)
        begin
            w_held <= 1'b0;
        end
    end
end

// write response: one per executed write, held off while pending
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `SRFU_RESP_OKAY;
    end
    else if (do_write)
    begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= strobe_ok(aw_addr);
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
        s_axi_bvalid <= 1'b0;
    end
end

// status flags, changed by a control op or a direct write
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        status_register <= `SRFU_STATUS_REGISTER_RESET;
    end
    else if (ctrl_hit)
    begin
        status_register <= next_status;
    end
    else if (status_register_hit)
    begin
        status_register <= w_data[7:0];
    end
end

// interrupt enable mirrors bit 7 of every status update
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        irq_global_enable <= 1'b0;
    end
    else if (ctrl_hit)
    begin
        irq_global_enable <= next_status[`SRFU_FLAG_I];
    end
    else if (status_register_hit)
    begin
        irq_global_enable <= w_data[`SRFU_FLAG_I];
    end
end

// result and readback of the last control op
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        result_reg <= 8'h00;
        operand <= 8'h00;
        last_op <= `SRFU_OP_NOP;
        last_idx <= 3'd0;
        op_count <= 3'd0;
    end
    else if (ctrl_hit)
    begin
        result_reg <= next_result;
        operand <= wr_operand;
        last_op <= op;
        last_idx <= idx;
        op_count <= op_count + 3'd1;
    end
end

// readback word for the address on the read channel
always @*
begin
    next_rdata = 32'h00000000;
    next_rresp = `SRFU_RESP_OKAY;
    case (word_addr(s_axi_araddr))
        `SRFU_ADDR_CTRL:
            next_rdata = {16'h0000, operand, 1'b0, last_idx, last_op};
        `SRFU_ADDR_STATUS:
            next_rdata = {29'h0, op_count};
        `SRFU_ADDR_RESULT:
            next_rdata = {24'h000000, result_reg};
        `SRFU_ADDR_STATUS_REGISTER:
            next_rdata = {24'h000000, status_register};
        default:
        begin
            next_rdata = 32'h00000000;
            next_rresp = `SRFU_RESP_DECERR;
        end
    endcase
end

// read channel
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `SRFU_RESP_OKAY;
    end
    else
    begin
        s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule

// ### verilog/srfu_defs.vh
`ifndef SRFU_DEFS_VH
`define SRFU_DEFS_VH

// status register flag positions
`define SRFU_FLAG_C 3'd0
`define SRFU_FLAG_Z 3'd1
`define SRFU_FLAG_N 3'd2
`define SRFU_FLAG_V 3'd3
`define SRFU_FLAG_S 3'd4
`define SRFU_FLAG_H 3'd5
`define SRFU_FLAG_T 3'd6
`define SRFU_FLAG_I 3'd7

// operation codes
`define SRFU_OP_NOP 4'h0
`define SRFU_OP_SHL 4'h1
`define SRFU_OP_SHR 4'h2
`define SRFU_OP_ROL 4'h3
`define SRFU_OP_ROR 4'h4
`define SRFU_OP_ASR 4'h5
`define SRFU_OP_SWAP 4'h6
`define SRFU_OP_RAISE 4'h7
`define SRFU_OP_LOWER 4'h8
`define SRFU_OP_TSTORE 4'h9
`define SRFU_OP_TLOAD 4'hA

// axi-lite map
`define SRFU_ADDR_CTRL 4'h0
`define SRFU_ADDR_STATUS 4'h4
`define SRFU_ADDR_RESULT 4'h8
`define SRFU_ADDR_STATUS_REGISTER 4'hC
`define SRFU_RESP_OKAY 2'b00
`define SRFU_RESP_DECERR 2'b11
`define SRFU_STATUS_REGISTER_RESET 8'h00

`endif

// ### verilog/srfu_shift.v
`timescale 1ns/1ns
module srfu_shift
(
    input wire [3:0] op,
    input wire [7:0] operand,
    input wire carry_in,
    output reg [7:0] result,
    output reg carry_out
);
`include "srfu_defs.vh"

always @*
begin
    result = operand;
    carry_out = carry_in;
    case (op)
        `SRFU_OP_SHL:
        begin
            result = {operand[6:0], 1'b0};
            carry_out = operand[7];
        end
        `SRFU_OP_SHR:
        begin
            result = {1'b0, operand[7:1]};
            carry_out = operand[0];
        end
        `SRFU_OP_ROL:
        begin
            result = {operand[6:0], carry_in};
            carry_out = operand[7];
        end
        `SRFU_OP_ROR:
        begin
            result = {carry_in, operand[7:1]};
            carry_out = operand[0];
        end
        `SRFU_OP_ASR:
        begin
            result = {operand[7], operand[7:1]};
            carry_out = operand[0];
        end
        `SRFU_OP_SWAP:
        begin
            result = {operand[3:0], operand[7:4]};
        end
        default:
        begin
            result = operand;
            carry_out = carry_in;
        end
    endcase
end

endmodule

// ### verilog/srfu_bit_sel.v
`timescale 1ns/1ns
module srfu_bit_sel
(
    input wire [7:0] value,
    input wire [2:0] index,
    input wire new_bit,
    output wire picked,
    output wire [7:0] replaced
);

genvar g;
assign picked = value[index];
generate
    for (g = 0; g < 8; g = g + 1)
    begin : gen_bit
        assign replaced[g] = (index == g) ? new_bit : value[g];
    end
endgenerate

endmodule

// ### bench/srfu_rf_model.sv
`timescale 1ns/1ns
module srfu_rf_model
(
    input wire aclk,
    input wire aresetn,
    input wire bvalid,
    input wire [7:0] result,
    output reg [7:0] working
);
    // write-back of each completed operation
    always @(posedge aclk)
    begin
        if (!aresetn)
            working <= 8'h00;
        else if (bvalid)
            working <= result;
    end
endmodule

// ### bench/srfu_chk.sv
`timescale 1ns/1ns
module srfu_chk
(
    input wire aclk,
    input wire aresetn,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [7:0] status_register,
    input wire [7:0] result_reg,
    input wire irq_global_enable
);
    wire go = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready && s_axi_awaddr[3:2] == 2'b00 && s_axi_wstrb[1];
    wire [3:0] op = s_axi_wdata[3:0];
    wire [7:0] opd = s_axi_wdata[15:8];
    wire [2:0] idx = s_axi_wdata[6:4];
    wire tbit = opd[idx];
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // op executes one edge after the handshake, seen one edge later
    shl_result_a: assert property (
        go && op == 4'h1 |-> ##2 result_reg == ($past(opd, 2) << 1))
        else $error("shift left result wrong");
    asr_result_a: assert property (
        go && op == 4'h5 |-> ##2 result_reg ==
        {$past(opd[7], 2), $past(opd[7:1], 2)})
        else $error("arithmetic shift result wrong");
    shift_flags_a: assert property (
        go && op >= 4'h1 && op <= 4'h5 |-> ##2 status_register[3:1] ==
        {status_register[2] ^ status_register[0], result_reg[7],
        result_reg == 8'h00})
        else $error("shift flags wrong");
    swap_quiet_a: assert property (
        go && op == 4'h6 |-> ##2 $stable(status_register) &&
        result_reg == {$past(opd[3:0], 2), $past(opd[7:4], 2)})
        else $error("swap wrong");
    raise_bit_a: assert property (
        go && op == 4'h7 |-> ##2 status_register[$past(idx, 2)])
        else $error("raised bit not set");
    tstore_bit_a: assert property (
        go && op == 4'h9 |-> ##2 status_register[6] == $past(tbit, 2))
        else $error("transfer flag wrong");
    tload_bit_a: assert property (
        go && op == 4'hA |-> ##2
        result_reg[$past(idx, 2)] == status_register[6])
        else $error("loaded bit wrong");
    irq_mirror_a: assert property (
        irq_global_enable == status_register[7])
        else $error("interrupt enable differs");
endmodule

bind srfu_top srfu_chk chk_u (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .status_register, .result_reg,
    .irq_global_enable);

// ### bench/srfu_top_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((e) !== (g)) begin \
    num_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module srfu_top_tb;
    localparam [63:0] PAT = 64'h810040C3A501FE80;
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg [3:0] awa = 4'h0;
    reg [3:0] ara = 4'h0;
    reg [31:0] wd = 32'h0;
    reg awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    wire awr, wrd, bv, arr, rv, irq;
    wire [1:0] br, rr;
    wire [31:0] rd;
    wire [7:0] sr, res, rf;
    integer num_errors = 0, compares = 0, i, j;
    reg [31:0] q;
    reg [1:0] rsp;
    reg [15:0] e;
    reg [7:0] d, s;
    always #20 aclk = ~aclk;
    srfu_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rre), .status_register(sr), .result_reg(res),
        .irq_global_enable(irq));
    srfu_rf_model rf_u (.aclk(aclk), .aresetn(aresetn), .bvalid(bv),
        .result(res), .working(rf));
    task print_verdict;
    begin
        if (num_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    task wr(input [3:0] a, input [31:0] v);
        integer n;
        begin
            awa <= a;
            wd <= v;
            awv <= 1'b1;
            wv <= 1'b1;
            bre <= 1'b1;
            n = 0;
            while (n < 40)
            begin
                @(posedge aclk);
                n++;
                if (awr) awv <= 1'b0;
                if (wrd) wv <= 1'b0;
                if (bv)
                begin
                    rsp = br;
                    bre <= 1'b0;
                    n = 99;
                end
            end
            if (n == 40)
            begin
                num_errors++;
                print_verdict;
            end
            @(posedge aclk);
        end
    endtask
    task rdr(input [3:0] a);
        integer n;
        begin
            ara <= a;
            arv <= 1'b1;
            rre <= 1'b1;
            n = 0;
            while (n < 40)
            begin
                @(posedge aclk);
                n++;
                if (arr) arv <= 1'b0;
                if (rv)
                begin
                    q = rd;
                    rsp = rr;
                    rre <= 1'b0;
                    n = 99;
                end
            end
            if (n == 40)
            begin
                num_errors++;
                print_verdict;
            end
            @(posedge aclk);
        end
    endtask
    function [15:0] model(input [3:0] op, input [2:0] ix, input [7:0] v,
        input [7:0] f);
        reg [7:0] r;
        reg c;
        begin
            r = v;
            c = f[0];
            case (op)
                4'h1: {c, r} = {v, 1'b0};
                4'h2: {r, c} = {1'b0, v};
                4'h3: {c, r} = {v, f[0]};
                4'h4: {r, c} = {f[0], v};
                4'h5: {r, c} = {v[7], v};
                4'h6: r = {v[3:0], v[7:4]};
                4'h7: f[ix] = 1'b1;
                4'h8: f[ix] = 1'b0;
                4'h9: f[6] = v[ix];
                4'hA: r[ix] = f[6];
                default: r = v;
            endcase
            if (op >= 4'h1 && op <= 4'h5)
                f[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
            model = {f, r};
        end
    endfunction
    initial
    begin
        repeat (16) @(posedge aclk);
        `CHK("reset status_register", 8'h00, sr)
        aresetn <= 1'b1;
        @(posedge aclk);
        // every op but nop, every bit index, carry and transfer both ways
        for (i = 1; i <= 10; i++)
            for (j = 0; j < 8; j++)
            begin
                d = PAT[j * 8 +: 8];
                s = (i == 8) ? 8'hFF : (8'h41 & {8{j[0]}});
                e = model(i[3:0], j[2:0], d, s);
                wr(4'hC, {24'h0, s});
                wr(4'h0, {16'h0, d, 1'b0, j[2:0], i[3:0]});
                `CHK("status_register", e[15:8], sr)
                `CHK("flags", e[11:8], sr[3:0])
                `CHK("high", e[15:12], sr[7:4])
                `CHK("irq", e[15], irq)
                if (i <= 6 || i == 10)
                begin
                    rdr(4'h8);
                    `CHK("result", {24'h0, e[7:0]}, q)
                    `CHK("rresp", 2'b00, rsp)
                    `CHK("working", e[7:0], rf)
                end
            end
        // write to a read-only place is refused
        wr(4'h8, 32'h000000FF);
        `CHK("bresp", 2'b11, rsp)
        `CHK("status_register kept", e[15:8], sr)
        rdr(4'hC);
        `CHK("status_register read", {24'h0, e[15:8]}, q)
        // nop leaves flags and result alone but is still counted
        wr(4'h0, 32'h00005A00);
        `CHK("nop bresp", 2'b00, rsp)
        `CHK("nop status_register", e[15:8], sr)
        rdr(4'h8);
        `CHK("nop result", {24'h0, e[7:0]}, q)
        rdr(4'h4);
        `CHK("op count", 32'h00000001, q)
        rdr(4'h0);
        `CHK("last op", 32'h00005A00, q)
        print_verdict;
    end
endmodule
